/* File: bench/tb_tmr_core.sv */
// Self-checking testbench of the timer slice
`timescale 1ns/100ps
`include "tmr_defs.svh"
module tb_tmr_core;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [3:0] vector_ack_i = 4'h0;
   logic [7:0] rdata_o;
   logic cap_pin;
   logic cnt_pin;
   logic cmp_a;
   logic cmp_b;
   logic [3:0] flags_o;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h7629;
   logic [15:0] v;
   logic [3:0] m;
   logic [7:0] d;
   logic [3:0] modes [15] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
                              4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
   tmr_core #(.FILTER_LEN(4)) u_dut (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_input_pin_i(cap_pin),
      .external_count_pin_i(cnt_pin), .vector_ack_i(vector_ack_i),
      .compare_output_a_o(cmp_a), .compare_output_b_o(cmp_b), .flags_o(flags_o));
   tmr_pin_model u_pins (.sys_clk_i(sys_clk_i), .cap_pin_o(cap_pin), .cnt_pin_o(cnt_pin));
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [15:0] top_of(input logic [3:0] md);
      case (md[2:0])
         3'h0: return md[3] ? 16'h0020 : 16'hFFFF;
         3'h1, 3'h5: return md[3] ? 16'h0020 : 16'h00FF;
         3'h2, 3'h6: return md[3] ? 16'h0020 : 16'h01FF;
         3'h3, 3'h7: return md[3] ? 16'h0020 : 16'h03FF;
         default: return 16'h0020;
      endcase
   endfunction
   function automatic logic early_ov(input logic [3:0] md);
      return md == 4'h0 || md[2:0] == 3'h5 || md[2:0] == 3'h6 || md[2:0] == 3'h7;
   endfunction
   // Prescaler division as a power of two for clock select codes 1 to 5
   function automatic int div_shift(input int cs);
      return cs == 1 ? 0 : (cs == 2 ? 3 : 2 * cs);
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] dv);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= dv;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] dv);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1;
      dv = rdata_o;
   endtask
   task automatic wr16(input logic [3:0] a, input logic [15:0] dv);
      wr(a + 4'h1, dv[15:8]);
      wr(a, dv[7:0]);
   endtask
   task automatic rd16(input logic [3:0] a, output logic [15:0] dv);
      rd(a, dv[7:0]);
      rd(a + 4'h1, dv[15:8]);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic chk_near(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if ((got + 16'h0001 >= exp && got <= exp + 16'h0004) !== 1'b1) begin
         err_count++;
         $display("Error %0t: count %h not near %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Compares %0d, errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (4) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      rd(`TMR_OFS_CTRL_B, d);
      chk({8'h00, d}, 16'h0000);
      wr(`TMR_OFS_CTRL_B, 8'hF8);
      rd(`TMR_OFS_CTRL_B, d);
      chk({8'h00, d}, 16'h00D8);
      rd(4'h3, d);
      chk({8'h00, d}, 16'h0000);
      wr(`TMR_OFS_CTRL_B, 8'h00);
      wr16(`TMR_OFS_CNT_L, 16'hA55A);
      rd16(`TMR_OFS_CNT_L, v);
      chk(v, 16'hA55A);
      wr(`TMR_OFS_CMPA_H, 8'h12);
      wr(`TMR_OFS_CMPB_H, 8'h34);
      wr(`TMR_OFS_CMPA_L, 8'h56);
      rd16(`TMR_OFS_CMPA_L, v);
      chk(v, 16'h3456);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr16(`TMR_OFS_CMPA_L, seed[15:0]);
         wr16(`TMR_OFS_CMPB_L, seed[31:16]);
         rd16(`TMR_OFS_CMPA_L, v);
         chk(v, seed[15:0]);
         rd16(`TMR_OFS_CMPB_L, v);
         chk(v, seed[31:16]);
      end
      for (int c = 1; c < 8; c++) begin
         wr16(`TMR_OFS_CNT_L, 16'h0000);
         wr(`TMR_OFS_CTRL_B, 8'(c));
         if (c > 5) begin
            u_pins.cnt_pulses(5);
         end else begin
            repeat (2048) @(posedge sys_clk_i);
         end
         settle(4);
         wr(`TMR_OFS_CTRL_B, 8'h00);
         rd16(`TMR_OFS_CNT_L, v);
         if (c > 5) begin
            chk(v, 16'h0005);
         end else begin
            chk_near(v, 16'h0804 >> div_shift(c));
         end
      end
      wr16(`TMR_OFS_CMPA_L, 16'h0010);
      wr16(`TMR_OFS_CMPB_L, 16'h0014);
      wr16(`TMR_OFS_CNT_L, 16'h0000);
      wr(`TMR_OFS_FLAGS, 8'h27);
      wr(`TMR_OFS_CTRL_B, 8'h01);
      settle(30);
      wr(`TMR_OFS_CTRL_B, 8'h00);
      #1 chk({12'h000, flags_o}, 16'h0006);
      wr(`TMR_OFS_FLAGS, 8'h04);
      #1 chk({12'h000, flags_o}, 16'h0002);
      @(posedge sys_clk_i);
      vector_ack_i <= 4'h2;
      @(posedge sys_clk_i);
      vector_ack_i <= 4'h0;
      settle(1);
      chk_bit(flags_o[1], 1'b0);
      wr16(`TMR_OFS_CNT_L, 16'h0100);
      wr(`TMR_OFS_CTRL_B, 8'h01);
      wr16(`TMR_OFS_CNT_L, 16'h0010);
      settle(4);
      wr(`TMR_OFS_CTRL_B, 8'h00);
      chk_bit(flags_o[1], 1'b0);
      wr(`TMR_OFS_FLAGS, 8'h27);
      for (int k = 0; k < 3; k++) begin
         m = k == 1 ? 4'h5 : 4'h0;
         wr(`TMR_OFS_CTRL_B, {3'h0, m[3:2], 3'h0});
         wr(`TMR_OFS_CTRL_A, k == 0 ? 8'hF0 : {6'h28, m[1:0]});
         wr(`TMR_OFS_FORCE, 8'hC0);
         settle(2);
         chk({14'h0000, cmp_a, cmp_b}, k == 2 ? 16'h0000 : 16'h0003);
         chk_bit(flags_o[1], 1'b0);
         rd(`TMR_OFS_FORCE, d);
         chk({8'h00, d}, 16'h0000);
      end
      for (int e = 0; e < 4; e++) begin
         seed = lfsr(seed);
         wr16(`TMR_OFS_CNT_L, seed[15:0]);
         wr(`TMR_OFS_CTRL_B, e[0] ? 8'h40 : (e == 2 ? 8'hC0 : 8'h58));
         u_pins.cap_pulse(e == 2 ? 2 : 6);
         settle(8);
         chk_bit(flags_o[3], e[0]);
         rd16(`TMR_OFS_CAP_L, v);
         if (e[0]) chk(v, seed[15:0]);
         wr(`TMR_OFS_FLAGS, 8'h20);
      end
      wr(`TMR_OFS_CTRL_B, 8'hC0);
      u_pins.cap_pulse(8);
      settle(8);
      chk_bit(flags_o[3], 1'b1);
      wr16(`TMR_OFS_CMPA_L, 16'h0020);
      wr(`TMR_OFS_CTRL_B, 8'h18);
      wr16(`TMR_OFS_CAP_L, 16'h0020);
      rd16(`TMR_OFS_CAP_L, v);
      chk(v, 16'h0020);
      foreach (modes[i]) begin
         m = modes[i];
         wr(`TMR_OFS_CTRL_B, 8'h00);
         wr(`TMR_OFS_CTRL_A, {6'h00, m[1:0]});
         wr16(`TMR_OFS_CNT_L, top_of(m) - 16'h0004);
         wr(`TMR_OFS_FLAGS, 8'h27);
         wr(`TMR_OFS_CTRL_B, {3'h0, m[3:2], 3'h1});
         settle(12);
         chk_bit(flags_o[0], early_ov(m));
         if (!early_ov(m)) begin
            settle(1100);
            chk_bit(flags_o[0], m != 4'h4 && m != 4'hC);
         end
      end
      wrap_up();
   end
endmodule

/* File: bench/tmr_core_asserts.sv */
// Port-level assertions of the timer slice
`timescale 1ns/100ps
`include "tmr_defs.svh"
module tmr_core_chk #(
   parameter int FILTER_LEN = 4
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic capture_input_pin_i,
   input wire logic external_count_pin_i,
   input wire logic [3:0] vector_ack_i,
   input wire logic compare_output_a_o,
   input wire logic compare_output_b_o,
   input wire logic [3:0] flags_o
);
   logic [7:0] ctla_reg;
   logic [7:0] ctlb_reg;
   wire logic [3:0] mode = {ctlb_reg[4:3], ctla_reg[1:0]};
   wire logic stop = ctlb_reg[2:0] == 3'h0;
   wire logic pwm = !(mode == 4'h0 || mode == 4'h4 || mode[3:1] == 3'h6);
   wire logic cap_top = mode[3] && !mode[0];
   wire logic frc_wr = wr_i && addr_i == `TMR_OFS_FORCE;
   // Shadow of both control registers, seen from the bus
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctla_reg <= 8'h00;
         ctlb_reg <= 8'h00;
      end else if (wr_i && addr_i == `TMR_OFS_CTRL_A) begin
         ctla_reg <= wdata_i;
      end else if (wr_i && addr_i == `TMR_OFS_CTRL_B) begin
         ctlb_reg <= wdata_i;
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   chk_force_rd0: assert property (
      $past(rd_i) && $past(addr_i) == `TMR_OFS_FORCE |-> rdata_o == 8'h00)
      else $error("force strobes read nonzero");
   chk_resv_rd0: assert property (
      $past(rd_i) && $past(addr_i) == `TMR_OFS_CTRL_B |-> !rdata_o[5])
      else $error("reserved control bit reads one");
   chk_flag_clr: assert property (
      $fell(flags_o[1]) |-> $past(vector_ack_i[1])
      || $past(wr_i && addr_i == `TMR_OFS_FLAGS && wdata_i[1]))
      else $error("match flag cleared without cause");
   chk_stop_still: assert property (
      stop && $past(stop) && $past(stop, 2) |-> !$rose(flags_o[0]) && !$rose(flags_o[2]))
      else $error("flag set while counter stopped");
   chk_force_set: assert property (
      frc_wr && wdata_i[7] && !pwm && ctla_reg[7:6] == 2'h3 |-> ##[1:2] compare_output_a_o)
      else $error("forced match did not set output");
   chk_force_pwm: assert property (
      frc_wr && pwm && stop && $past(stop)
      |=> ($stable(compare_output_a_o) && $stable(compare_output_b_o)) [*2])
      else $error("force strobe acted in pwm mode");
   chk_cap_edge: assert property (
      $rose(capture_input_pin_i) && ctlb_reg[6] && !ctlb_reg[7] && !cap_top
      |-> ##[1:3] flags_o[3])
      else $error("rising edge did not capture");
   chk_cap_filt: assert property (
      $rose(capture_input_pin_i) && ctlb_reg[7] && ctlb_reg[6] && !flags_o[3]
      |-> !flags_o[3] [*3])
      else $error("filtered capture came too early");
   chk_cap_off: assert property (
      cap_top && stop && $past(stop) |-> !$rose(flags_o[3]))
      else $error("capture while capture value is top");
   cov_force: cover property (frc_wr && wdata_i[7]);
   cov_cap: cover property ($rose(flags_o[3]));
   cov_ovf: cover property ($rose(flags_o[0]));
endmodule
bind tmr_core tmr_core_chk #(.FILTER_LEN(FILTER_LEN)) u_chk (
   .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_input_pin_i(capture_input_pin_i),
   .external_count_pin_i(external_count_pin_i), .vector_ack_i(vector_ack_i),
   .compare_output_a_o(compare_output_a_o), .compare_output_b_o(compare_output_b_o),
   .flags_o(flags_o));

/* File: bench/tmr_pin_model.sv */
// Pin-side model driving the capture pin and the external count pin
`timescale 1ns/100ps
module tmr_pin_model (
   input wire logic sys_clk_i,
   output logic cap_pin_o,
   output logic cnt_pin_o
);
   initial begin
      cap_pin_o = 1'b0;
      cnt_pin_o = 1'b0;
   end
   // High pulse of w clock cycles on the capture pin
   task automatic cap_pulse(input int w);
      @(posedge sys_clk_i);
      cap_pin_o <= 1'b1;
      repeat (w) @(posedge sys_clk_i);
      cap_pin_o <= 1'b0;
   endtask
   // Each pulse gives exactly one rising and one falling edge
   task automatic cnt_pulses(input int n);
      repeat (n) begin
         @(posedge sys_clk_i);
         cnt_pin_o <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
         cnt_pin_o <= 1'b0;
         repeat (3) @(posedge sys_clk_i);
      end
   endtask
endmodule

/* File: hdl/tmr_core.sv */
// Timer/counter mode decode, prescaler, capture, compare and register slice
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tmr_core
   import tmr_pkg::*;
#(
   parameter int FILTER_LEN = `TMR_FILTER_LEN
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [`TMR_ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic capture_input_pin_i,
   input wire logic external_count_pin_i,
   input wire logic [3:0] vector_ack_i,
   output logic compare_output_a_o,
   output logic compare_output_b_o,
   output logic [3:0] flags_o
);
   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   if (FILTER_LEN < 2 || FILTER_LEN > 16) begin : g_bad_filter
      $error("FILTER_LEN out of range");
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] ctrl_a_reg;
   logic [7:0] ctrl_b_reg;
   logic [7:0] hold_reg;
   logic [7:0] rdata_reg;
   logic [15:0] cnt_reg;
   logic [15:0] cap_reg;
   logic [15:0] cmpa_reg;
   logic [15:0] cmpb_reg;
   logic [15:0] cmpa_buf_reg;
   logic [15:0] cmpb_buf_reg;
   logic [3:0] flag_reg;
   logic dir_down_reg;
   logic cnt_wr_blk_reg;
   logic oa_reg;
   logic ob_reg;
   logic [10:0] pre_reg;
   logic ext_d_reg;
   logic cap_d_reg;
   logic filt_reg;
   logic [FILTER_LEN-1:0] samp_reg;
   logic [1:0] mdone_reg;

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   wire [3:0] mode = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
   wire [2:0] clk_sel = ctrl_b_reg[2:0];
   tmr_top_src_t top_src;
   tmr_point_t upd_pt;
   tmr_point_t ov_pt;
   logic [15:0] fix_top;
   logic phase_mode;
   logic fast_mode;
   always_comb begin
      top_src = TMR_TOP_FIX;
      upd_pt = TMR_PT_IMM;
      ov_pt = TMR_PT_IMM;
      fix_top = `TMR_TOP_MAX;
      phase_mode = 1'b0;
      fast_mode = 1'b0;
      case (mode)
         4'd0: begin
            fix_top = `TMR_TOP_MAX;
         end
         4'd4: top_src = TMR_TOP_CMPA;
         4'd12: top_src = TMR_TOP_CAP;
         4'd1, 4'd2, 4'd3, 4'd10, 4'd11: begin
            phase_mode = 1'b1;
            upd_pt = TMR_PT_TOP;
            ov_pt = TMR_PT_BOT;
            fix_top = (mode == 4'd1) ? `TMR_TOP_8 : (mode == 4'd2) ? `TMR_TOP_9 : `TMR_TOP_10;
            top_src = (mode == 4'd10) ? TMR_TOP_CAP :
                      (mode == 4'd11) ? TMR_TOP_CMPA : TMR_TOP_FIX;
         end
         4'd5, 4'd6, 4'd7, 4'd14, 4'd15: begin
            fast_mode = 1'b1;
            upd_pt = TMR_PT_BOT;
            ov_pt = TMR_PT_TOP;
            fix_top = (mode == 4'd5) ? `TMR_TOP_8 : (mode == 4'd6) ? `TMR_TOP_9 : `TMR_TOP_10;
            top_src = (mode == 4'd14) ? TMR_TOP_CAP :
                      (mode == 4'd15) ? TMR_TOP_CMPA : TMR_TOP_FIX;
         end
         4'd8, 4'd9: begin
            phase_mode = 1'b1;
            upd_pt = TMR_PT_BOT;
            ov_pt = TMR_PT_BOT;
            top_src = (mode == 4'd8) ? TMR_TOP_CAP : TMR_TOP_CMPA;
         end
         default: begin
            top_src = TMR_TOP_FIX; // Reserved mode 13 runs as normal
         end
      endcase
   end
   wire pwm_mode = phase_mode | fast_mode;
   wire [15:0] top_val = (top_src == TMR_TOP_CMPA) ? cmpa_reg :
                         (top_src == TMR_TOP_CAP) ? cap_reg : fix_top;

   // ----------------------------------------
   // Clock source and prescaler
   // ----------------------------------------
   // Count pin is sampled whatever its port direction, so software can clock it
   wire ext_edge = (clk_sel == 3'b110) ? (ext_d_reg & ~external_count_pin_i) :
                   (ext_d_reg ^ 1'b1) & external_count_pin_i;
   wire [10:0] pre_wrap = (clk_sel == 3'b010) ? `TMR_DIV_8 : (clk_sel == 3'b011) ? `TMR_DIV_64 :
                          (clk_sel == 3'b100) ? `TMR_DIV_256 : `TMR_DIV_1024;
   wire pre_hit = (pre_reg == pre_wrap - 11'd1);
   wire tick = (clk_sel == 3'b000) ? 1'b0 :
               (clk_sel == 3'b001) ? 1'b1 :
               (clk_sel[2:1] == 2'b11) ? ext_edge : pre_hit;

   // ----------------------------------------
   // Counter sequencing
   // ----------------------------------------
   wire at_top = (cnt_reg == top_val);
   wire at_bot = (cnt_reg == `TMR_BOTTOM);
   wire at_max = (cnt_reg == `TMR_TOP_MAX);
   wire ctc_mode = (mode == 4'd4) || (mode == 4'd12);
   logic [15:0] cnt_step;
   logic dir_next;
   always_comb begin
      dir_next = dir_down_reg;
      if (phase_mode) begin
         if (at_top) begin
            dir_next = 1'b1;
         end else if (at_bot) begin
            dir_next = 1'b0;
         end
         cnt_step = dir_next ? cnt_reg - 16'd1 : cnt_reg + 16'd1;
      end else if (fast_mode || ctc_mode) begin
         dir_next = 1'b0;
         cnt_step = at_top ? `TMR_BOTTOM : cnt_reg + 16'd1;
      end else begin
         dir_next = 1'b0;
         cnt_step = cnt_reg + 16'd1;
      end
   end
   // Overflow at BOTTOM only on the way down, not when a period starts
   wire ov_hit = (ov_pt == TMR_PT_BOT) ? at_bot & dir_down_reg :
                 (ov_pt == TMR_PT_TOP) ? at_top : at_max;
   wire upd_hit = (upd_pt == TMR_PT_TOP) ? at_top : (upd_pt == TMR_PT_BOT) ? at_bot : 1'b1;

   // ----------------------------------------
   // Compare and capture
   // ----------------------------------------
   // A counter write holds off matches until the next tick has passed
   wire match_a = tick & ~cnt_wr_blk_reg & (cnt_reg == cmpa_reg);
   wire match_b = tick & ~cnt_wr_blk_reg & (cnt_reg == cmpb_reg);
   wire force_ok = wr_i & (addr_i == `TMR_OFS_FORCE) & ~pwm_mode;
   wire force_a = force_ok & wdata_i[`TMR_FORCE_A_BIT];
   wire force_b = force_ok & wdata_i[`TMR_FORCE_B_BIT];
   wire cap_src = ctrl_b_reg[`TMR_B_NOISE_BIT] ? filt_reg : samp_reg[0];
   // Capture-top modes cut the pin off; the flag then marks TOP instead
   wire cap_conn = (top_src != TMR_TOP_CAP);
   wire cap_edge = ctrl_b_reg[`TMR_B_EDGE_BIT] ? (cap_src & ~cap_d_reg) :
                   (~cap_src & cap_d_reg);
   wire cap_evt = cap_conn & cap_edge;
   wire samp_same = (samp_reg == {FILTER_LEN{samp_reg[0]}});
   wire [3:0] flag_set = {cap_evt | (~cap_conn & tick & at_top), mdone_reg, tick & ov_hit};
   wire flag_wr = wr_i & (addr_i == `TMR_OFS_FLAGS);
   wire [3:0] flag_clr = vector_ack_i | ({4{flag_wr}} & {wdata_i[5], wdata_i[2:0]});

   // Waveform action for one channel
   function automatic tmr_act_t act_of(input logic [1:0] com, input logic up);
      tmr_act_t r;
      r = TMR_ACT_KEEP;
      if (com == 2'b10) begin
         r = up ? TMR_ACT_LOW : TMR_ACT_HIGH;
      end else if (com == 2'b11) begin
         r = up ? TMR_ACT_HIGH : TMR_ACT_LOW;
      end
      return r;
   endfunction
   function automatic logic apply(input logic cur, input logic [1:0] com, input logic hit,
                                  input logic up);
      logic r;
      r = cur;
      if (hit) begin
         if (com == 2'b01) begin
            r = ~cur;
         end else if (act_of(com, up) == TMR_ACT_LOW) begin
            r = 1'b0;
         end else if (act_of(com, up) == TMR_ACT_HIGH) begin
            r = 1'b1;
         end
      end
      return r;
   endfunction
   // Only phase modes count down; the match action flips on the way down
   wire up_now = ~(phase_mode & dir_down_reg);

   // ----------------------------------------
   // Register access
   // ----------------------------------------
   wire wr_cnt_l = wr_i & (addr_i == `TMR_OFS_CNT_L);
   wire wr_hi = wr_i & ((addr_i == `TMR_OFS_CNT_H) | (addr_i == `TMR_OFS_CMPA_H) |
                        (addr_i == `TMR_OFS_CMPB_H) | (addr_i == `TMR_OFS_CAP_H));
   wire [15:0] wr_word = {hold_reg, wdata_i};
   logic [7:0] rd_next;
   always_comb begin
      case (addr_i)
         `TMR_OFS_CTRL_A: rd_next = ctrl_a_reg;
         `TMR_OFS_CTRL_B: rd_next = ctrl_b_reg & `TMR_CTRL_B_MASK;
         `TMR_OFS_FORCE: rd_next = 8'h00;
         `TMR_OFS_CNT_L: rd_next = cnt_reg[7:0];
         `TMR_OFS_CAP_L: rd_next = cap_reg[7:0];
         `TMR_OFS_CMPA_L: rd_next = cmpa_buf_reg[7:0];
         `TMR_OFS_CMPB_L: rd_next = cmpb_buf_reg[7:0];
         `TMR_OFS_CNT_H, `TMR_OFS_CAP_H, `TMR_OFS_CMPA_H, `TMR_OFS_CMPB_H: rd_next = hold_reg;
         `TMR_OFS_FLAGS: rd_next = {2'b00, flag_reg[3], 2'b00, flag_reg[2:0]};
         default: rd_next = 8'h00;
      endcase
   end
   // A low-byte read snapshots the high byte so the pair stays coherent
   wire [7:0] hold_next = wr_hi ? wdata_i :
                          ~rd_i ? hold_reg :
                          (addr_i == `TMR_OFS_CNT_L) ? cnt_reg[15:8] :
                          (addr_i == `TMR_OFS_CAP_L) ? cap_reg[15:8] :
                          (addr_i == `TMR_OFS_CMPA_L) ? cmpa_buf_reg[15:8] :
                          (addr_i == `TMR_OFS_CMPB_L) ? cmpb_buf_reg[15:8] : hold_reg;

   // ----------------------------------------
   // Sequential logic
   // ----------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_a_reg <= `TMR_CTRL_A_RST;
         ctrl_b_reg <= `TMR_CTRL_B_RST;
         hold_reg <= 8'h00;
         rdata_reg <= 8'h00;
         pre_reg <= 11'd0;
         ext_d_reg <= 1'b0;
         samp_reg <= '0;
         filt_reg <= 1'b0;
         cap_d_reg <= 1'b0;
      end else begin
         if (wr_i && addr_i == `TMR_OFS_CTRL_A) begin
            ctrl_a_reg <= wdata_i & `TMR_CTRL_A_MASK;
         end
         if (wr_i && addr_i == `TMR_OFS_CTRL_B) begin
            ctrl_b_reg <= wdata_i & `TMR_CTRL_B_MASK;
         end
         hold_reg <= hold_next;
         rdata_reg <= rd_i ? rd_next : 8'h00;
         pre_reg <= (clk_sel[2:1] == 2'b11 || clk_sel == 3'b000 || pre_hit) ? 11'd0
                    : pre_reg + 11'd1;
         ext_d_reg <= external_count_pin_i;
         samp_reg <= {samp_reg[FILTER_LEN-2:0], capture_input_pin_i};
         if (samp_same) begin
            filt_reg <= samp_reg[0];
         end
         cap_d_reg <= cap_src;
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= 16'h0000;
         dir_down_reg <= 1'b0;
         cnt_wr_blk_reg <= 1'b0;
         cap_reg <= 16'h0000;
         cmpa_reg <= 16'h0000;
         cmpb_reg <= 16'h0000;
         cmpa_buf_reg <= 16'h0000;
         cmpb_buf_reg <= 16'h0000;
         flag_reg <= 4'h0;
         mdone_reg <= 2'b00;
         oa_reg <= 1'b0;
         ob_reg <= 1'b0;
      end else begin
         if (wr_cnt_l) begin
            cnt_reg <= wr_word;
            cnt_wr_blk_reg <= 1'b1;
         end else if (tick) begin
            cnt_reg <= cnt_step;
            dir_down_reg <= dir_next;
            cnt_wr_blk_reg <= 1'b0;
         end
         if (wr_i && addr_i == `TMR_OFS_CAP_L && !cap_conn) begin
            cap_reg <= wr_word;
         end else if (cap_evt) begin
            cap_reg <= cnt_reg;
         end
         if (wr_i && addr_i == `TMR_OFS_CMPA_L) begin
            cmpa_buf_reg <= wr_word;
         end
         if (wr_i && addr_i == `TMR_OFS_CMPB_L) begin
            cmpb_buf_reg <= wr_word;
         end
         if (upd_pt == TMR_PT_IMM || (tick && upd_hit)) begin
            cmpa_reg <= (wr_i && addr_i == `TMR_OFS_CMPA_L) ? wr_word : cmpa_buf_reg;
            cmpb_reg <= (wr_i && addr_i == `TMR_OFS_CMPB_L) ? wr_word : cmpb_buf_reg;
         end
         mdone_reg <= {match_b, match_a};
         // Set wins over a clear in the same cycle
         flag_reg <= (flag_reg & ~flag_clr) | flag_set;
         oa_reg <= apply(oa_reg, ctrl_a_reg[7:6], match_a | force_a, up_now);
         ob_reg <= apply(ob_reg, ctrl_a_reg[5:4], match_b | force_b, up_now);
      end
   end

   assign rdata_o = rdata_reg;
   assign compare_output_a_o = oa_reg;
   assign compare_output_b_o = ob_reg;
   assign flags_o = flag_reg;
endmodule

/* File: hdl/tmr_defs.svh */
// Register offsets, field positions, reset values and timing constants of the timer slice
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define TMR_ADDR_W 4
`define TMR_OFS_CTRL_A 4'h0
`define TMR_OFS_CTRL_B 4'h1
`define TMR_OFS_FORCE 4'h2
`define TMR_OFS_CNT_L 4'h4
`define TMR_OFS_CNT_H 4'h5
`define TMR_OFS_CAP_L 4'h6
`define TMR_OFS_CAP_H 4'h7
`define TMR_OFS_CMPA_L 4'h8
`define TMR_OFS_CMPA_H 4'h9
`define TMR_OFS_CMPB_L 4'hA
`define TMR_OFS_CMPB_H 4'hB
`define TMR_OFS_FLAGS 4'hC
`define TMR_CTRL_B_RST 8'h00
`define TMR_CTRL_A_RST 8'h00
`define TMR_CTRL_A_MASK 8'hF3
`define TMR_CTRL_B_MASK 8'hDF
`define TMR_B_NOISE_BIT 7
`define TMR_B_EDGE_BIT 6
`define TMR_FORCE_A_BIT 7
`define TMR_FORCE_B_BIT 6
`define TMR_FLAG_CAP_BIT 5
`define TMR_FLAG_MB_BIT 2
`define TMR_FLAG_MA_BIT 1
`define TMR_FLAG_OV_BIT 0
`define TMR_TOP_MAX 16'hFFFF
`define TMR_TOP_8 16'h00FF
`define TMR_TOP_9 16'h01FF
`define TMR_TOP_10 16'h03FF
`define TMR_BOTTOM 16'h0000
`define TMR_FILTER_LEN 4
`define TMR_DIV_8 11'd8
`define TMR_DIV_64 11'd64
`define TMR_DIV_256 11'd256
`define TMR_DIV_1024 11'd1024
`endif

/* File: hdl/tmr_pkg.sv */
// Types of the timer slice
package tmr_pkg;
   typedef enum logic [2:0] {
      TMR_TOP_FIX = 3'b001,
      TMR_TOP_CMPA = 3'b010,
      TMR_TOP_CAP = 3'b100
   } tmr_top_src_t;
   typedef enum logic [2:0] {
      TMR_PT_IMM = 3'b001,
      TMR_PT_TOP = 3'b010,
      TMR_PT_BOT = 3'b100
   } tmr_point_t;
   typedef enum logic [2:0] {
      TMR_ACT_KEEP = 3'b001,
      TMR_ACT_LOW = 3'b010,
      TMR_ACT_HIGH = 3'b100
   } tmr_act_t;
endpackage
